// ===== opm_mode_ctrl.sv
// operating-mode controller: mode sequencing, image cycle, breakpoints,
// watchdog, cycle monitor, indicators and overall reset
// assumes an execution core answering each request with a step_done pulse
`timescale 1ns/10ps
// How it works
// - exactly one of four modes held
// - stopped: no program, outputs off, stop lit
// - stopping keeps images, timers, counters, flags
// - stop to run passes start-up routine
// - run lamp blinks at least 3 s
// - start-up inhibits outputs, then enters running
// - running cycles main routine, run lamp lit
// - running releases the output inhibit
// - at most three breakpoints, set by station
// - breakpoint hit enters hold, station steps
// - hold stops code, freezes timers, inhibits
// - hold keeps clock and connections alive
// - over two breakpoints refuses single step
// - 100 ms watchdog, cycle limit, fault stops
// - run to stop drives analog safe values
// - stopped remote outputs off, inputs cyclic
// - clear inputs, start-up, release, then cycle
// - remote inputs read once on start
// - cycle order read, main, write
// - overall reset erases user memory only
// - overall reset from switch or station
// - stop lamp blinks during reset, then steady
module opm_mode_ctrl import opm_pkg::*; #(
	parameter int MS_CYC = MS_CYC_DEF,
	parameter int AW = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// front-panel mode switch pins
	input wire opm_sw_t sw_pins,
	// programming station
	input wire logic stn_run_req,
	input wire logic stn_stop_req,
	input wire logic stn_memory_reset_position_req,
	input wire logic stn_step_req,
	input wire logic stn_resume_req,
	input wire logic bp_set,
	input wire logic bp_del,
	input wire logic bp_del_all,
	input wire logic bp_enable,
	input wire logic [BP_IDX_W-1:0] bp_index,
	input wire logic [AW-1:0] bp_addr,
	output logic step_refused,
	output logic reg_view_en,
	// execution core
	input wire logic exec_valid,
	input wire logic [AW-1:0] exec_pc,
	input wire logic step_done,
	input wire logic wd_kick,
	input wire opm_ms_t cfg_cycle_ms,
	output opm_cmd_t cmd,
	output logic exec_enable,
	output logic timers_run,
	output logic rtc_enable,
	// process outputs and remote i/o
	input wire logic cfg_use_subst,
	output logic output_inhibit,
	output logic analog_safe,
	output logic analog_subst,
	output logic remote_cyclic,
	// user memory
	input wire logic mem_clear_done,
	output logic mem_clear_req,
	// status and indicators
	output opm_ind_t ind,
	output logic [1:0] mode_code,
	output opm_fault_t fault
);

	localparam int TW = $clog2(MS_CYC);

	// reset release, asserted asynchronously
	logic rst_s1_reg;
	logic rst_n;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_reg <= 1'h0;
			rst_n <= 1'h0;
		end else begin
			rst_s1_reg <= 1'h1;
			rst_n <= rst_s1_reg;
		end
	end

	// millisecond tick, shared by every timer
	logic [TW-1:0] ms_cnt_reg;
	wire ms_tick = (ms_cnt_reg == TW'(MS_CYC - 1));
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt_reg <= '0;
		end else begin
			ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + TW'(1);
		end
	end

	// switch synchroniser
	logic [2:0] sw_q;
	opm_sync3 #(.W(3)) u_sw_sync (
		.clk(core_clk),
		.rst_n(rst_n),
		.d(sw_pins),
		.q(sw_q)
	);
	wire opm_sw_t sw = opm_sw_t'(sw_q);

	// state
	opm_mode_t mode_reg, mode_next;
	opm_step_t step_reg, step_next;
	opm_mr_t mr_reg, mr_next;
	logic run_cmd_reg, run_cmd_next;
	logic sw_run_q_reg; // switch run level one cycle ago
	opm_fault_t fault_reg;
	logic [AW-1:0] bp_addr_reg [NUM_BP];
	logic [NUM_BP-1:0] bp_on_reg;
	logic [NUM_BP-1:0] hit_vec;
	logic [AW-1:0] hold_pc_reg; // pc where hold was entered
	logic ign_reg; // skip the breakpoint just resumed from
	logic flash_reg; // common blink phase

	// timer status
	logic hold_zero, wd_zero, cyc_zero, mr_zero, flash_zero;

	// count of breakpoints currently defined
	function automatic logic [BP_IDX_W-1:0] bp_count(input logic [NUM_BP-1:0] v);
		logic [BP_IDX_W-1:0] c;
		c = '0;
		for (int i = 0; i < NUM_BP; i++) begin
			c = c + BP_IDX_W'(v[i]);
		end
		return c;
	endfunction

	// request pattern for each step
	function automatic opm_cmd_t cmd_of(input opm_step_t s);
		opm_cmd_t c;
		c = '0;
		case (s)
			S_CLR_IN: begin
				c.clr_in = 1'h1;
				c.remote_once = 1'h1;
			end
			S_STARTUP: c.startup = 1'h1;
			S_CLR_OUT: c.clr_out = 1'h1;
			S_READ: c.read_in = 1'h1;
			S_EXEC: c.main_run = 1'h1;
			S_WRITE: c.write_out = 1'h1;
			default: c = '0;
		endcase
		return c;
	endfunction

	// start and stop conditions
	wire sw_run_rise = sw.run && !sw_run_q_reg;
	wire memory_reset_position_busy = (mr_reg == MR_CLEAR);
	wire start_ev = (sw_run_rise || stn_run_req) && sw.run && !memory_reset_position_busy;
	wire stop_ev = !sw.run || stn_stop_req;
	wire in_run = (mode_reg == M_RUN);
	wire in_hold = (mode_reg == M_HOLD);
	wire [BP_IDX_W-1:0] bp_cnt = bp_count(bp_on_reg);
	wire bp_hit = in_run && step_reg == S_EXEC && exec_valid && bp_enable
		&& (|hit_vec) && !(ign_reg && exec_pc == hold_pc_reg);
	wire step_ok = in_hold && stn_step_req && bp_cnt <= STEP_MAX_BP;
	wire step_no = in_hold && stn_step_req && bp_cnt > STEP_MAX_BP;

	// faults: start-up is not watched, hold freezes both timers
	wire timers_tick = ms_tick && !in_hold;
	wire wd_fault = in_run && wd_zero;
	wire cyc_fault = in_run && cyc_zero;
	wire fault_any = wd_fault || cyc_fault;
	wire stop_now = !run_cmd_reg || fault_any;
	wire opm_ms_t cyc_lim = (cfg_cycle_ms < CYC_MIN_MS) ? CYC_MIN_MS : cfg_cycle_ms;
	wire cyc_start = in_run && step_reg != S_READ && step_next == S_READ;

	// run command level from switch and station
	always_comb begin
		run_cmd_next = run_cmd_reg;
		if (stop_ev || fault_any) begin
			run_cmd_next = 1'h0;
		end else if (start_ev) begin
			run_cmd_next = 1'h1;
		end
	end

	// mode and process-image sequencing
	always_comb begin
		mode_next = mode_reg;
		step_next = step_reg;
		case (mode_reg)
			M_STOP: begin
				step_next = S_IDLE;
				// an erase starting this cycle keeps the cpu stopped
				if (run_cmd_reg && !memory_reset_position_busy && mr_next != MR_CLEAR) begin
					mode_next = M_START;
					step_next = S_CLR_IN;
				end
			end
			M_START: begin
				if (stop_now) begin
					mode_next = M_STOP;
					step_next = S_IDLE;
				end else if (step_done && step_reg == S_CLR_IN) begin
					step_next = S_STARTUP;
				end else if (step_done && step_reg == S_STARTUP) begin
					mode_next = M_RUN;
					step_next = S_CLR_OUT;
				end
			end
			M_RUN: begin
				if (stop_now) begin
					mode_next = M_STOP;
					step_next = S_IDLE;
				end else if (bp_hit) begin
					mode_next = M_HOLD;
				end else if (step_done) begin
					case (step_reg)
						S_CLR_OUT: step_next = S_READ;
						S_READ: step_next = S_EXEC;
						S_EXEC: step_next = S_WRITE;
						default: step_next = S_READ;
					endcase
				end
			end
			M_HOLD: begin
				if (stop_now) begin
					mode_next = M_STOP;
					step_next = S_IDLE;
				end else if (stn_resume_req) begin
					mode_next = M_RUN;
				end
			end
			default: begin
				mode_next = M_STOP;
				step_next = S_IDLE;
			end
		endcase
	end

	// overall reset sequence, only while stopped
	always_comb begin
		mr_next = mr_reg;
		case (mr_reg)
			MR_IDLE: begin
				if (mode_reg == M_STOP && stn_memory_reset_position_req) begin
					mr_next = MR_CLEAR;
				end else if (mode_reg == M_STOP && sw.memory_reset_position) begin
					mr_next = MR_ARMING;
				end
			end
			MR_ARMING: begin
				if (!sw.memory_reset_position) begin
					mr_next = MR_IDLE;
				end else if (mr_zero) begin
					mr_next = MR_ARMED;
				end
			end
			MR_ARMED: begin
				if (stn_memory_reset_position_req) begin
					mr_next = MR_CLEAR;
				end else if (!sw.memory_reset_position) begin
					mr_next = MR_WINDOW;
				end
			end
			MR_WINDOW: begin
				if (sw.memory_reset_position || stn_memory_reset_position_req) begin
					mr_next = MR_CLEAR;
				end else if (mr_zero) begin
					mr_next = MR_IDLE;
				end
			end
			MR_CLEAR: begin
				if (mem_clear_done) begin
					mr_next = MR_IDLE;
				end
			end
			default: mr_next = MR_IDLE;
		endcase
		if (mode_reg != M_STOP && mr_reg != MR_CLEAR) begin
			mr_next = MR_IDLE;
		end
	end

	// state registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= M_STOP;
			step_reg <= S_IDLE;
			mr_reg <= MR_IDLE;
			run_cmd_reg <= 1'h0;
			sw_run_q_reg <= 1'h0;
		end else begin
			mode_reg <= mode_next;
			step_reg <= step_next;
			mr_reg <= mr_next;
			run_cmd_reg <= run_cmd_next;
			sw_run_q_reg <= sw.run;
		end
	end

	// fault flags: a new fault wins over the clear by a fresh start
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_reg <= '0;
		end else begin
			fault_reg.wdog <= wd_fault || (fault_reg.wdog && !start_ev);
			fault_reg.cycle <= cyc_fault || (fault_reg.cycle && !start_ev);
		end
	end

	// breakpoint table, set and deleted by the station
	generate
		for (genvar i = 0; i < NUM_BP; i++) begin : g_bp
			wire sel = (bp_index == BP_IDX_W'(i));
			assign hit_vec[i] = bp_on_reg[i] && bp_addr_reg[i] == exec_pc;
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					bp_addr_reg[i] <= '0;
					bp_on_reg[i] <= 1'h0;
				end else if (bp_set && sel) begin
					bp_addr_reg[i] <= bp_addr;
					bp_on_reg[i] <= 1'h1;
				end else if (bp_del_all || (bp_del && sel)) begin
					bp_on_reg[i] <= 1'h0;
				end
			end
		end
	endgenerate

	// resume skips the breakpoint until the pc moves on
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_pc_reg <= '0;
			ign_reg <= 1'h0;
		end else if (bp_hit) begin
			hold_pc_reg <= exec_pc;
			ign_reg <= 1'h0;
		end else if (in_hold && stn_resume_req) begin
			ign_reg <= 1'h1;
		end else if (exec_valid && exec_pc != hold_pc_reg) begin
			ign_reg <= 1'h0;
		end
	end

	// timers: start-up blink hold, watchdog, cycle limit, reset, flash
	wire hold_load = step_reg != S_STARTUP && step_next == S_STARTUP;
	wire mr_load = mr_next != mr_reg;
	opm_count u_hold (
		.clk(core_clk), .rst_n(rst_n), .load(hold_load), .load_val(BLINK_HOLD_MS),
		.tick(ms_tick), .zero(hold_zero)
	);
	opm_count u_wdog (
		.clk(core_clk), .rst_n(rst_n), .load(wd_kick || !in_run && !in_hold),
		.load_val(WDOG_MS), .tick(timers_tick), .zero(wd_zero)
	);
	opm_count u_cyc (
		.clk(core_clk), .rst_n(rst_n), .load(cyc_start || !in_run && !in_hold),
		.load_val(cyc_lim), .tick(timers_tick), .zero(cyc_zero)
	);
	opm_count u_mr (
		.clk(core_clk), .rst_n(rst_n), .load(mr_load),
		.load_val(mr_next == MR_ARMING ? MEMORY_RESET_POSITION_ARM_MS : MEMORY_RESET_POSITION_WIN_MS),
		.tick(ms_tick), .zero(mr_zero)
	);
	opm_count u_flash (
		.clk(core_clk), .rst_n(rst_n), .load(flash_zero), .load_val(FLASH_MS),
		.tick(ms_tick), .zero(flash_zero)
	);

	// indicator and output decode of the next state
	wire run_led_next = !hold_zero ? flash_reg :
		(mode_next == M_RUN) ? 1'h1 :
		(mode_next == M_HOLD) ? flash_reg : 1'h0;
	wire stop_blink = (mr_next == MR_ARMING) || (mr_next == MR_CLEAR);
	wire stop_led_next = (mode_next == M_STOP) ? !stop_blink || flash_reg :
		(mode_next == M_HOLD);
	wire exec_next = (mode_next == M_RUN && step_next == S_EXEC)
		|| (mode_next == M_START && step_next == S_STARTUP) || step_ok;
	wire opm_cmd_t cmd_next = (mode_next == M_START || mode_next == M_RUN)
		? cmd_of(step_next) : '0;

	// registered outputs
	opm_cmd_t cmd_reg;
	opm_ind_t ind_reg;
	logic exec_reg, refused_reg, view_reg, timers_reg;
	logic inhibit_reg, safe_reg, subst_reg, cyclic_reg, clear_reg;
	logic [1:0] code_reg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_reg <= '0;
			ind_reg <= '0;
			exec_reg <= 1'h0;
			refused_reg <= 1'h0;
			view_reg <= 1'h0;
			timers_reg <= 1'h0;
			inhibit_reg <= 1'h1;
			safe_reg <= 1'h1;
			subst_reg <= 1'h0;
			cyclic_reg <= 1'h1;
			clear_reg <= 1'h0;
			code_reg <= CODE_STOP;
			flash_reg <= 1'h0;
		end else begin
			cmd_reg <= cmd_next;
			ind_reg.run_led <= run_led_next;
			ind_reg.stop_led <= stop_led_next;
			exec_reg <= exec_next;
			refused_reg <= step_no;
			view_reg <= (mode_next == M_HOLD);
			timers_reg <= (mode_next == M_RUN);
			inhibit_reg <= (mode_next != M_RUN);
			safe_reg <= (mode_next == M_STOP);
			subst_reg <= (mode_next == M_STOP) && cfg_use_subst;
			cyclic_reg <= (mode_next == M_STOP);
			clear_reg <= (mr_next == MR_CLEAR);
			case (mode_next)
				M_START: code_reg <= CODE_START;
				M_RUN: code_reg <= CODE_RUN;
				M_HOLD: code_reg <= CODE_HOLD;
				default: code_reg <= CODE_STOP;
			endcase
			if (flash_zero) begin
				flash_reg <= !flash_reg;
			end
		end
	end

	assign cmd = cmd_reg;
	assign ind = ind_reg;
	assign exec_enable = exec_reg;
	assign step_refused = refused_reg;
	assign reg_view_en = view_reg;
	assign timers_run = timers_reg;
	assign rtc_enable = 1'h1; // clock and links never gated by hold
	assign output_inhibit = inhibit_reg;
	assign analog_safe = safe_reg;
	assign analog_subst = subst_reg;
	assign remote_cyclic = cyclic_reg;
	assign mem_clear_req = clear_reg;
	assign mode_code = code_reg;
	assign fault = fault_reg;

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_read_done;
		in_run && step_reg == S_READ && step_done && !stop_now && !bp_hit;
	endsequence
	sequence s_exec_done;
		in_run && step_reg == S_EXEC && step_done && !stop_now && !bp_hit;
	endsequence

	property p_inhibit_not_run;
		!in_run |=> output_inhibit || mode_reg == M_RUN;
	endproperty
	a_inhibit_not_run: assert property (p_inhibit_not_run)
		else $error("outputs enabled outside running mode");

	property p_stop_to_start;
		mode_reg == M_STOP ##1 mode_reg != M_STOP |-> mode_reg == M_START;
	endproperty
	a_stop_to_start: assert property (p_stop_to_start)
		else $error("left stop without start-up");

	property p_blink_hold;
		$rose(cmd_reg.startup) |-> !hold_zero [*8];
	endproperty
	a_blink_hold: assert property (p_blink_hold)
		else $error("start-up blink hold not running");

	property p_bp_hold;
		bp_hit && !stop_now |=> mode_reg == M_HOLD ##1 ind.stop_led && output_inhibit;
	endproperty
	a_bp_hold: assert property (p_bp_hold)
		else $error("breakpoint did not enter hold");

	property p_step_refused;
		step_no |=> step_refused && !exec_enable;
	endproperty
	a_step_refused: assert property (p_step_refused)
		else $error("single step not refused");

	property p_wdog_stop;
		wd_fault |=> mode_reg == M_STOP && fault.wdog ##1 output_inhibit;
	endproperty
	a_wdog_stop: assert property (p_wdog_stop)
		else $error("watchdog did not stop the cpu");

	property p_cycle_order;
		s_read_done |=> step_reg == S_EXEC && cmd.main_run;
	endproperty
	a_cycle_order: assert property (p_cycle_order)
		else $error("main routine did not follow input read");

	property p_write_after_exec;
		s_exec_done |=> step_reg == S_WRITE && cmd.write_out;
	endproperty
	a_write_after_exec: assert property (p_write_after_exec)
		else $error("output write did not follow main routine");

	property p_clear_only_stop;
		mem_clear_req |-> $past(mode_reg) == M_STOP && !cmd.main_run;
	endproperty
	a_clear_only_stop: assert property (p_clear_only_stop)
		else $error("memory clear outside stop");

endmodule

// ===== opm_pkg.sv
// shared types and constants for the operating-mode controller
// assumes one 125 MHz system clock; timers count whole milliseconds
package opm_pkg;

	// clock rate and derived millisecond tick
	localparam int CLK_HZ = 125_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYC_DEF = CLK_HZ / MS_PER_S;

	// millisecond timer values
	localparam int MS_W = 12;
	typedef logic [MS_W-1:0] opm_ms_t;
	localparam opm_ms_t BLINK_HOLD_MS = 12'hbb8; // 3000 ms start-up blink
	localparam opm_ms_t WDOG_MS = 12'h064; // 100 ms watchdog
	localparam opm_ms_t CYC_MIN_MS = 12'h001; // 1 ms least cycle limit
	localparam opm_ms_t MEMORY_RESET_POSITION_ARM_MS = 12'hbb8; // 3000 ms switch hold to arm
	localparam opm_ms_t MEMORY_RESET_POSITION_WIN_MS = 12'hbb8; // 3000 ms window to confirm
	localparam opm_ms_t FLASH_MS = 12'h0fa; // 250 ms half period of blink

	// breakpoints
	localparam int NUM_BP = 3;
	localparam int BP_IDX_W = 2;
	localparam logic [BP_IDX_W-1:0] STEP_MAX_BP = 2'h2;

	// external 2-bit mode status codes
	localparam logic [1:0] CODE_STOP = 2'h0;
	localparam logic [1:0] CODE_START = 2'h1;
	localparam logic [1:0] CODE_RUN = 2'h2;
	localparam logic [1:0] CODE_HOLD = 2'h3;

	// modes, process-image steps, overall reset sequence
	typedef enum logic [1:0] {M_STOP, M_START, M_RUN, M_HOLD} opm_mode_t;
	typedef enum logic [2:0] {
		S_IDLE, S_CLR_IN, S_STARTUP, S_CLR_OUT, S_READ, S_EXEC, S_WRITE
	} opm_step_t;
	typedef enum logic [2:0] {MR_IDLE, MR_ARMING, MR_ARMED, MR_WINDOW, MR_CLEAR} opm_mr_t;

	// front-panel switch positions
	typedef struct packed {
		logic run;
		logic stop;
		logic memory_reset_position;
	} opm_sw_t;

	// requests to the execution core, held until step_done
	typedef struct packed {
		logic clr_in;
		logic remote_once;
		logic startup;
		logic clr_out;
		logic read_in;
		logic main_run;
		logic write_out;
	} opm_cmd_t;

	// indicators
	typedef struct packed {
		logic run_led;
		logic stop_led;
	} opm_ind_t;

	// latched faults
	typedef struct packed {
		logic wdog;
		logic cycle;
	} opm_fault_t;

endpackage

// ===== opm_sync3.sv
// three-stage input synchroniser for pins from outside the clock domain
// assumes rst_n is already synchronous to clk
`timescale 1ns/10ps
module opm_sync3 import opm_pkg::*; #(
	parameter int W = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins in, settled value out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] s1_reg; // only read by s2_reg
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] q_reg;

	// a change counts only once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q_reg <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < W; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					q_reg[i] <= s3_reg[i];
				end
			end
		end
	end

	assign q = q_reg;

endmodule

// ===== opm_count.sv
// loadable millisecond down-counter, stops at zero
// assumes tick is a one-cycle pulse on the same clock
`timescale 1ns/10ps
module opm_count import opm_pkg::*; #(
	parameter int W = MS_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic tick,
	// status
	output logic zero
);

	logic [W-1:0] cnt_reg; // remaining ticks

	// load wins over counting so a restart is never missed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (load) begin
			cnt_reg <= load_val;
		end else if (tick && cnt_reg != '0) begin
			cnt_reg <= cnt_reg - W'(1);
		end
	end

	assign zero = (cnt_reg == '0);

endmodule

// ===== opm_core_model.sv
// execution core and i/o model that answers the mode controller
// assumes cmd stands until step_done and the 125 MHz system clock
`timescale 1ns/10ps
module opm_core_model import opm_pkg::*; (
	// clock
	input wire logic core_clk,
	// from the controller
	input wire opm_cmd_t cmd,
	input wire logic exec_enable,
	input wire logic mem_clear_req,
	// bench knobs: answer delay, kicks, address reported
	input wire logic [3:0] dly,
	input wire logic kick_en,
	input wire logic [15:0] hit_pc,
	// answers
	output logic step_done,
	output logic exec_valid,
	output logic [15:0] exec_pc,
	output logic wd_kick,
	output logic mem_clear_done
);
	int n = 0; // cycles spent on this request
	int t = 0; // free-running count
	opm_cmd_t last = '0; // request answered last, not answered twice
	logic need_en; // code steps advance only while enabled
	assign need_en = cmd.startup | cmd.main_run;
	assign exec_valid = cmd.main_run & exec_enable;
	// invalid address keeps changing so a stale match cannot hide
	assign exec_pc = exec_valid ? hit_pc : t[15:0];
	// signals change just after the edge
	always @(posedge core_clk) begin
		#1;
		t = t + 1;
		step_done = 0;
		wd_kick = kick_en && (t % 50 == 0);
		mem_clear_done = mem_clear_req && (t % 40 == 0);
		if (cmd == '0) begin
			last = '0;
			n = 0;
		end else if (cmd != last && (!need_en || exec_enable)) begin
			n = n + 1;
			// answer once dly cycles have been spent on the request
			if (n >= dly) begin
				step_done = 1;
				last = cmd;
				n = 0;
			end
		end
	end
endmodule

// ===== opm_mode_ctrl_bench.sv
// self-checking bench of the operating-mode controller
// assumes the core model answers every request
`timescale 1ns/10ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; $display("wrong value %s expected %h seen %h", n, e, a); end end
module opm_mode_ctrl_bench import opm_pkg::*;;
	logic core_clk = 0, rst_b = 0, bp_enable = 0, cfg_use_subst = 0, kick_en = 1;
	opm_sw_t sw_pins = '0;
	logic [7:0] pul = '0; // station pulses
	logic [1:0] bp_index = '0;
	logic [15:0] bp_addr = '0, hit_pc = '0, exec_pc, pc;
	logic [3:0] dly = 4'h3;
	opm_ms_t cfg_cycle_ms = 12'h005;
	logic step_done, exec_valid, wd_kick, mem_clear_done, step_refused, reg_view_en;
	logic exec_enable, timers_run, rtc_enable, output_inhibit, analog_safe;
	logic analog_subst, remote_cyclic, mem_clear_req;
	opm_cmd_t cmd;
	opm_ind_t ind;
	logic [1:0] mode_code;
	opm_fault_t fault;
	int miscompares = 0, num_checks = 0, seed = 32'h726ac67d, i, lows;
	logic [6:0] seq[$]; // requests seen
	logic [6:0] exp_seq[7] = '{7'h60, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01, 7'h04};
	always #4 core_clk = ~core_clk;
	opm_mode_ctrl #(.MS_CYC(10), .AW(16)) DUT (.core_clk, .rst_b, .sw_pins,
		.stn_run_req(pul[0]), .stn_stop_req(pul[1]), .stn_memory_reset_position_req(pul[2]),
		.stn_step_req(pul[3]), .stn_resume_req(pul[4]), .bp_set(pul[5]),
		.bp_del(pul[6]), .bp_del_all(pul[7]), .bp_enable, .bp_index, .bp_addr,
		.step_refused, .reg_view_en, .exec_valid, .exec_pc, .step_done, .wd_kick,
		.cfg_cycle_ms, .cmd, .exec_enable, .timers_run, .rtc_enable, .cfg_use_subst,
		.output_inhibit, .analog_safe, .analog_subst, .remote_cyclic,
		.mem_clear_done, .mem_clear_req, .ind, .mode_code, .fault);
	opm_core_model core (.core_clk, .cmd, .exec_enable, .mem_clear_req, .dly,
		.kick_en, .hit_pc, .step_done, .exec_valid, .exec_pc, .wd_kick,
		.mem_clear_done);
	// log the first requests in answer order
	always @(posedge core_clk) begin
		if (step_done && cmd != '0 && seq.size() < 7) seq.push_back(cmd);
	end
	// one station pulse of one cycle
	task pulse(int k);
		@(negedge core_clk) pul[k] = 1;
		@(negedge core_clk) pul = '0;
	endtask
	// bounded wait for a mode, then compare it
	task wait_mode(logic [1:0] m, int lim);
		for (i = 0; i < lim && mode_code !== m; i++) @(negedge core_clk);
		`CHK("mode", m, mode_code)
	endtask
	task note(string s);
		$display("test %s done", s);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// a hang counts as a mismatch
	initial begin
		#720000;
		miscompares++;
		end_of_test;
	end
	initial begin
		repeat (2) @(negedge core_clk);
		rst_b = 1;
		repeat (6) @(negedge core_clk);
		`CHK("mode", CODE_STOP, mode_code)
		`CHK("inhibit", 1'b1, output_inhibit)
		`CHK("leds", 2'b01, ind)
		`CHK("rtc", 1'b1, rtc_enable)
		note("reset");
		// switch overall reset: hold to arm, keep held, release, tip again
		lows = 0;
		sw_pins.memory_reset_position = 1;
		repeat (30100) begin
			@(negedge core_clk);
			lows += !ind.stop_led;
		end
		`CHK("arm blink", 1'b1, lows > 0)
		lows = 0;
		repeat (3000) begin
			@(negedge core_clk);
			lows += !ind.stop_led;
		end
		`CHK("armed steady", 0, lows)
		sw_pins.memory_reset_position = 0;
		repeat (100) @(negedge core_clk);
		sw_pins.memory_reset_position = 1;
		for (i = 0; i < 20 && mem_clear_req !== 1'b1; i++) @(negedge core_clk);
		`CHK("switch clear", 1'b1, mem_clear_req)
		sw_pins.memory_reset_position = 0;
		for (i = 0; i < 100 && mem_clear_req !== 1'b0; i++) @(negedge core_clk);
		`CHK("switch clear end", 1'b0, mem_clear_req)
		note("switch reset");
		dly = 4'(1 + ($random(seed) & 3));
		sw_pins.run = 1;
		wait_mode(CODE_START, 20);
		`CHK("start inhibit", 1'b1, output_inhibit)
		`CHK("start stop led", 1'b0, ind.stop_led)
		wait_mode(CODE_RUN, 200);
		@(negedge core_clk);
		`CHK("run inhibit", 1'b0, output_inhibit)
		`CHK("timers", 1'b1, timers_run)
		repeat (31000) @(negedge core_clk);
		`CHK("run leds", 2'b10, ind)
		foreach (exp_seq[j]) `CHK("cmd order", exp_seq[j], seq[j])
		note("start");
		pc = 16'($random(seed));
		hit_pc = pc;
		bp_addr = pc;
		pulse(5);
		bp_enable = 1;
		wait_mode(CODE_HOLD, 400);
		`CHK("hold inhibit", 1'b1, output_inhibit)
		`CHK("regs", 1'b1, reg_view_en)
		`CHK("hold leds", 1'b1, ind.stop_led)
		`CHK("frozen", 1'b0, timers_run)
		pulse(3);
		`CHK("step ok", 1'b0, step_refused)
		`CHK("step grant", 1'b1, exec_enable)
		for (int b = 1; b < 3; b++) begin
			bp_index = 2'(b);
			pulse(5);
		end
		pulse(3);
		`CHK("step refused", 1'b1, step_refused)
		`CHK("no step", 1'b0, exec_enable)
		pulse(7);
		hit_pc = ~pc;
		pulse(4);
		wait_mode(CODE_RUN, 20);
		note("hold");
		cfg_use_subst = 1;
		pulse(1);
		wait_mode(CODE_STOP, 20);
		@(negedge core_clk);
		`CHK("safe", 2'b11, {analog_safe, analog_subst})
		`CHK("remote", 1'b1, remote_cyclic)
		`CHK("stop exec", 2'b01, {exec_enable, output_inhibit})
		note("stop");
		pulse(2);
		for (i = 0; i < 20 && mem_clear_req !== 1'b1; i++) @(negedge core_clk);
		`CHK("clear req", 1'b1, mem_clear_req)
		for (i = 0; i < 100 && mem_clear_req !== 1'b0; i++) @(negedge core_clk);
		`CHK("clear end", 1'b0, mem_clear_req)
		@(negedge core_clk);
		`CHK("steady stop", 1'b1, ind.stop_led)
		note("overall reset");
		pulse(0);
		wait_mode(CODE_START, 20);
		wait_mode(CODE_RUN, 200);
		kick_en = 0;
		wait_mode(CODE_STOP, 1200);
		`CHK("fault", 2'b10, fault)
		note("watchdog");
		end_of_test;
	end
endmodule
